//--- verilog/timer16_pkg.sv
/*
 * Package for the 16-bit timer/counter core: register locations, reset
 * values, control field layout and waveform mode codes.
 * Assumes an 8-bit I/O bus with byte-wide read and write strobes.
 */
package timer16_pkg;

	// ------------------------------------------------------------
	// Register locations on the I/O bus
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL_A = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B = 4'h1;
	localparam logic [3:0] ADDR_CNT_LO = 4'h4;
	localparam logic [3:0] ADDR_CNT_HI = 4'h5;
	localparam logic [3:0] ADDR_CAP_LO = 4'h6;
	localparam logic [3:0] ADDR_CAP_HI = 4'h7;
	localparam logic [3:0] ADDR_CMPA_LO = 4'h8;
	localparam logic [3:0] ADDR_CMPA_HI = 4'h9;
	localparam logic [3:0] ADDR_CMPB_LO = 4'hA;
	localparam logic [3:0] ADDR_CMPB_HI = 4'hB;
	localparam logic [3:0] ADDR_FLAGS = 4'hC;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_A_MODE_LSB = 0;
	localparam int CTRL_B_MODE_LSB = 3;
	localparam int CTRL_B_SEL_LSB = 0;
	localparam int FLAG_OVF_BIT = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [2:0] SEL_STOPPED = 3'h0;

	// ------------------------------------------------------------
	// Fixed limits and waveform mode codes
	// ------------------------------------------------------------
	localparam logic [15:0] BOTTOM_VALUE = 16'h0000;
	localparam logic [15:0] MAX_VALUE = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;

	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_PC8 = 4'h1;
	localparam logic [3:0] MODE_PC9 = 4'h2;
	localparam logic [3:0] MODE_PC10 = 4'h3;
	localparam logic [3:0] MODE_CTC_A = 4'h4;
	localparam logic [3:0] MODE_FAST8 = 4'h5;
	localparam logic [3:0] MODE_FAST9 = 4'h6;
	localparam logic [3:0] MODE_FAST10 = 4'h7;
	localparam logic [3:0] MODE_PFC_CAP = 4'h8;
	localparam logic [3:0] MODE_PFC_A = 4'h9;
	localparam logic [3:0] MODE_PC_CAP = 4'hA;
	localparam logic [3:0] MODE_PC_A = 4'hB;
	localparam logic [3:0] MODE_CTC_CAP = 4'hC;
	localparam logic [3:0] MODE_FAST_CAP = 4'hE;
	localparam logic [3:0] MODE_FAST_A = 4'hF;

endpackage

//--- verilog/tick_select.sv
/*
 * Tick source selection: picks a prescaler tap or an external edge
 * by the three-bit select field and emits one tick enable.
 * Assumes prescaler taps and the external input are synchronous.
 */
`timescale 1ns/100ps

module tick_select
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] tickSourceSelect,
	input wire logic [4:0] prescaleTap,
	input wire logic extPin,
	output logic timerTick
);

	logic extPrev_q;
	logic extPrev_d;

	// ------------------------------------------------------------
	// External edge sampling
	// ------------------------------------------------------------
	always_comb
	begin
		extPrev_d = extPin;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			extPrev_q <= 1'b0;
		else
			extPrev_q <= extPrev_d;
	end

	// ------------------------------------------------------------
	// Source multiplexer
	// ------------------------------------------------------------
	always_comb
	begin
		case (tickSourceSelect)
			3'h0: timerTick = 1'b0;
			3'h1: timerTick = prescaleTap[0];
			3'h2: timerTick = prescaleTap[1];
			3'h3: timerTick = prescaleTap[2];
			3'h4: timerTick = prescaleTap[3];
			3'h5: timerTick = prescaleTap[4];
			3'h6: timerTick = extPrev_q & ~extPin;
			3'h7: timerTick = ~extPrev_q & extPin;
			default: timerTick = 1'b0;
		endcase
	end

endmodule

//--- verilog/timer16_counter_core.sv
/*
 * 16-bit timer/counter core: counter, shared high-byte latch, control
 * registers A and B, compare and capture holding registers, overflow
 * flag, limit indications.
 * Assumes a single-cycle 8-bit I/O bus with read and write strobes;
 * read data is registered and valid the cycle after the read strobe.
 */
// Behaviour
// - Counter sits at two byte locations
// - High-byte location accesses the shared latch
// - Low read loads latch; low write commits
// - Latch keeps its value between accesses
// - Three-bit select field picks tick source
// - Select zero stops all counting
// - Tick clears, increments or decrements counter
// - Clear forces all sixteen bits zero
// - Top and bottom limit indications
// - Counter accessible whether ticking or not
// - CPU write beats clear or count
// - Four-bit mode field across A and B
// - Overflow flag set per mode
// - One latch serves all wide registers
// - Compare reads bypass the latch
`timescale 1ns/100ps

module timer16_counter_core
#(
	parameter int COUNT_WIDTH = 16
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] busAddr,
	input wire logic busWrite,
	input wire logic busRead,
	input wire logic [7:0] busWdata,
	output logic [7:0] busRdata,
	input wire logic [4:0] prescaleTap,
	input wire logic extPin,
	input wire logic captureEvent,
	output logic timerTick,
	output logic atTop,
	output logic atBottom,
	output logic overflowFlag,
	output logic [3:0] waveformModeField,
	output logic [COUNT_WIDTH-1:0] countValue
);

	typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

	logic [COUNT_WIDTH-1:0] count_q, count_d;
	logic [7:0] latch_q, latch_d;
	logic [7:0] ctrlA_q, ctrlA_d;
	logic [7:0] ctrlB_q, ctrlB_d;
	logic [15:0] cmpA_q, cmpA_d;
	logic [15:0] cmpB_q, cmpB_d;
	logic [15:0] cap_q, cap_d;
	logic ovf_q, ovf_d;
	dir_t dir_q, dir_d;
	logic [7:0] rdata_q, rdata_d;
	logic [15:0] topValue;
	logic dualSlope;
	logic [2:0] tickSourceSelect;
	logic wrLo, rdLo;
	logic ovfSet, flagClr;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
		hit = (a == b);
	endfunction

	// ------------------------------------------------------------
	// Tick source
	// ------------------------------------------------------------
	assign tickSourceSelect = ctrlB_q[timer16_pkg::CTRL_B_SEL_LSB +: 3];

	tick_select tickSel
	(
		.clk(clk),
		.rst_n(rst_n),
		.tickSourceSelect(tickSourceSelect),
		.prescaleTap(prescaleTap),
		.extPin(extPin),
		.timerTick(timerTick)
	);

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	assign waveformModeField = {ctrlB_q[timer16_pkg::CTRL_B_MODE_LSB +: 2],
		ctrlA_q[timer16_pkg::CTRL_A_MODE_LSB +: 2]};

	always_comb
	begin
		dualSlope = 1'b0;
		case (waveformModeField)
			timer16_pkg::MODE_PC8: topValue = timer16_pkg::TOP_8BIT;
			timer16_pkg::MODE_FAST8: topValue = timer16_pkg::TOP_8BIT;
			timer16_pkg::MODE_PC9: topValue = timer16_pkg::TOP_9BIT;
			timer16_pkg::MODE_FAST9: topValue = timer16_pkg::TOP_9BIT;
			timer16_pkg::MODE_PC10: topValue = timer16_pkg::TOP_10BIT;
			timer16_pkg::MODE_FAST10: topValue = timer16_pkg::TOP_10BIT;
			timer16_pkg::MODE_CTC_A: topValue = cmpA_q;
			timer16_pkg::MODE_PFC_A: topValue = cmpA_q;
			timer16_pkg::MODE_PC_A: topValue = cmpA_q;
			timer16_pkg::MODE_FAST_A: topValue = cmpA_q;
			timer16_pkg::MODE_PFC_CAP: topValue = cap_q;
			timer16_pkg::MODE_PC_CAP: topValue = cap_q;
			timer16_pkg::MODE_CTC_CAP: topValue = cap_q;
			timer16_pkg::MODE_FAST_CAP: topValue = cap_q;
			// Reserved code counts as normal, up to all-ones
			default: topValue = timer16_pkg::MAX_VALUE;
		endcase
		case (waveformModeField)
			timer16_pkg::MODE_PC8, timer16_pkg::MODE_PC9,
			timer16_pkg::MODE_PC10, timer16_pkg::MODE_PFC_CAP,
			timer16_pkg::MODE_PFC_A, timer16_pkg::MODE_PC_CAP,
			timer16_pkg::MODE_PC_A: dualSlope = 1'b1;
			default: dualSlope = 1'b0;
		endcase
	end

	// Limit indications
	assign atTop = (count_q == topValue);
	assign atBottom = (count_q == timer16_pkg::BOTTOM_VALUE);

	// Low-byte strobes decoded once; the write steers the counter, the read the latch
	assign wrLo = busWrite && hit(busAddr, timer16_pkg::ADDR_CNT_LO);
	assign flagClr = busWrite && hit(busAddr, timer16_pkg::ADDR_FLAGS) &&
		busWdata[timer16_pkg::FLAG_OVF_BIT];
	assign rdLo = busRead && hit(busAddr, timer16_pkg::ADDR_CNT_LO);

	// ------------------------------------------------------------
	// Counter, direction and overflow flag
	// ------------------------------------------------------------
	always_comb
	begin
		count_d = count_q;
		dir_d = dir_q;
		ovf_d = ovf_q;
		ovfSet = 1'b0;
		if (timerTick)
		begin
			if (dualSlope)
			begin
				if (atTop)
				begin
					dir_d = DIR_DOWN;
					count_d = count_q - 16'h0001;
				end
				else if (atBottom && dir_q == DIR_DOWN)
				begin
					dir_d = DIR_UP;
					ovfSet = 1'b1;
					count_d = count_q + 16'h0001;
				end
				else if (dir_q == DIR_DOWN)
					count_d = count_q - 16'h0001;
				else
					count_d = count_q + 16'h0001;
			end
			else if (atTop)
			begin
				// Top at all-ones wraps the same way as a clear
				count_d = timer16_pkg::COUNT_RESET;
				dir_d = DIR_UP;
				if (waveformModeField != timer16_pkg::MODE_CTC_A &&
					waveformModeField != timer16_pkg::MODE_CTC_CAP)
					ovfSet = 1'b1;
			end
			else if (count_q == timer16_pkg::MAX_VALUE)
			begin
				// Top lowered below the count: roll over at MAX
				count_d = timer16_pkg::COUNT_RESET;
				ovfSet = 1'b1;
			end
			else
				count_d = count_q + 16'h0001;
		end
		if (wrLo)
			count_d = {latch_q, busWdata};
		// Flag cleared by writing one; a same-cycle set still wins so
		// that an overflow landing on the clear is never lost
		if (ovfSet)
			ovf_d = 1'b1;
		else if (flagClr)
			ovf_d = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_q <= timer16_pkg::COUNT_RESET;
			dir_q <= DIR_UP;
			ovf_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			dir_q <= dir_d;
			ovf_q <= ovf_d;
		end
	end

	// ------------------------------------------------------------
	// Shared latch, control and wide holding registers
	// ------------------------------------------------------------
	always_comb
	begin
		latch_d = latch_q;
		ctrlA_d = ctrlA_q;
		ctrlB_d = ctrlB_q;
		cmpA_d = cmpA_q;
		cmpB_d = cmpB_q;
		cap_d = cap_q;
		// Capture copies the live count; a capture low-byte write in the cycle wins
		if (captureEvent)
			cap_d = count_q;
		if (busWrite)
		begin
			case (busAddr)
				timer16_pkg::ADDR_CTRL_A: ctrlA_d = busWdata;
				timer16_pkg::ADDR_CTRL_B: ctrlB_d = busWdata;
				timer16_pkg::ADDR_CNT_HI, timer16_pkg::ADDR_CAP_HI,
				timer16_pkg::ADDR_CMPA_HI, timer16_pkg::ADDR_CMPB_HI:
					latch_d = busWdata;
				timer16_pkg::ADDR_CMPA_LO: cmpA_d = {latch_q, busWdata};
				timer16_pkg::ADDR_CMPB_LO: cmpB_d = {latch_q, busWdata};
				timer16_pkg::ADDR_CAP_LO: cap_d = {latch_q, busWdata};
				default: latch_d = latch_q;
			endcase
		end
		else if (busRead)
		begin
			if (rdLo)
				latch_d = count_q[15:8];
			else if (hit(busAddr, timer16_pkg::ADDR_CAP_LO))
				latch_d = cap_q[15:8];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			latch_q <= timer16_pkg::LATCH_RESET;
			ctrlA_q <= timer16_pkg::CTRL_RESET;
			ctrlB_q <= timer16_pkg::CTRL_RESET;
			cmpA_q <= timer16_pkg::COUNT_RESET;
			cmpB_q <= timer16_pkg::COUNT_RESET;
			cap_q <= timer16_pkg::COUNT_RESET;
		end
		else
		begin
			latch_q <= latch_d;
			ctrlA_q <= ctrlA_d;
			ctrlB_q <= ctrlB_d;
			cmpA_q <= cmpA_d;
			cmpB_q <= cmpB_d;
			cap_q <= cap_d;
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_comb
	begin
		rdata_d = 8'h00;
		if (busRead)
		begin
			case (busAddr)
				timer16_pkg::ADDR_CTRL_A: rdata_d = ctrlA_q;
				timer16_pkg::ADDR_CTRL_B: rdata_d = ctrlB_q;
				timer16_pkg::ADDR_CNT_LO: rdata_d = count_q[7:0];
				timer16_pkg::ADDR_CNT_HI: rdata_d = latch_q;
				timer16_pkg::ADDR_CAP_LO: rdata_d = cap_q[7:0];
				timer16_pkg::ADDR_CAP_HI: rdata_d = latch_q;
				timer16_pkg::ADDR_CMPA_LO: rdata_d = cmpA_q[7:0];
				timer16_pkg::ADDR_CMPA_HI: rdata_d = cmpA_q[15:8];
				timer16_pkg::ADDR_CMPB_LO: rdata_d = cmpB_q[7:0];
				timer16_pkg::ADDR_CMPB_HI: rdata_d = cmpB_q[15:8];
				timer16_pkg::ADDR_FLAGS: rdata_d = {7'h00, ovf_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Registered read data: one cycle late, but never glitches
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	assign busRdata = rdata_q;
	assign overflowFlag = ovf_q;
	assign countValue = count_q;

endmodule

//--- tb/timer16_counter_core_assertions.sv
/* Checker for the timer core, bound to its ports.
   Assumes one clock domain and the timer package compiled first. */
`timescale 1ns/100ps
module timer16_counter_core_chk
#(
	parameter int COUNT_WIDTH = 16
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] busAddr,
	input wire logic busWrite,
	input wire logic busRead,
	input wire logic [7:0] busWdata,
	input wire logic [7:0] busRdata,
	input wire logic timerTick,
	input wire logic atTop,
	input wire logic atBottom,
	input wire logic overflowFlag,
	input wire logic [3:0] waveformModeField,
	input wire logic [COUNT_WIDTH-1:0] countValue
);
	localparam logic [3:0] LO = timer16_pkg::ADDR_CNT_LO;
	localparam logic [3:0] HI = timer16_pkg::ADDR_CNT_HI;
	localparam logic [3:0] NRM = timer16_pkg::MODE_NORMAL;
	localparam logic [15:0] MAXV = timer16_pkg::MAX_VALUE;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_wrLo;
		busWrite && busAddr == HI ##1 busWrite && busAddr == LO
		|=> countValue == {$past(busWdata, 2), $past(busWdata)};
	endproperty
	a_wrLo: assert property (p_wrLo) else $error("wide write lost");
	property p_rdLo;
		busRead && !busWrite && busAddr == LO
		|=> busRdata == $past(countValue[7:0]);
	endproperty
	a_rdLo: assert property (p_rdLo) else $error("low read wrong");
	property p_rdHi;
		busRead && !busWrite && busAddr == LO
		##1 busRead && !busWrite && busAddr == HI
		|=> busRdata == $past(countValue[15:8], 2);
	endproperty
	a_rdHi: assert property (p_rdHi) else $error("high read wrong");
	property p_noTick;
		!timerTick && !(busWrite && busAddr == LO) |=> $stable(countValue);
	endproperty
	a_noTick: assert property (p_noTick) else $error("count moved");
	property p_bottom;
		atBottom == (countValue == 16'h0000);
	endproperty
	a_bottom: assert property (p_bottom) else $error("bottom wrong");
	property p_topN;
		waveformModeField == NRM |-> atTop == (countValue == MAXV);
	endproperty
	a_topN: assert property (p_topN) else $error("top wrong");
	property p_inc;
		timerTick && !busWrite && waveformModeField == NRM
		&& countValue != MAXV |=> countValue == $past(countValue) + 1'b1;
	endproperty
	a_inc: assert property (p_inc) else $error("no increment");
	property p_wrap;
		timerTick && !busWrite && waveformModeField == NRM
		&& countValue == MAXV |=> countValue == 16'h0000 && overflowFlag;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap wrong");
endmodule
bind timer16_counter_core timer16_counter_core_chk
	#(.COUNT_WIDTH(COUNT_WIDTH)) chk (.clk(clk), .rst_n(rst_n),
	.busAddr(busAddr), .busWrite(busWrite), .busRead(busRead),
	.busWdata(busWdata), .busRdata(busRdata), .timerTick(timerTick),
	.atTop(atTop), .atBottom(atBottom), .overflowFlag(overflowFlag),
	.waveformModeField(waveformModeField), .countValue(countValue));

//--- tb/cpu_bus_model.sv
/* Processor side of the 8-bit I/O bus: one byte access per cycle.
   Assumes the bench calls its tasks; lines change at falling edges. */
`timescale 1ns/100ps
module cpu_bus_model
(
	input wire logic clk,
	output logic [3:0] busAddr,
	output logic busWrite,
	output logic busRead,
	output logic [7:0] busWdata
);
	// Single master; a wide pair may be split by other accesses
	// Wide writes made with ticks idle and with ticks active
	initial
	begin
		busAddr = 4'h0;
		busWrite = 1'b0;
		busRead = 1'b0;
		busWdata = 8'h00;
	end
	task automatic put(input logic w, input logic r, input logic [3:0] a,
		input logic [7:0] d);
		@(negedge clk);
		busWrite = w;
		busRead = r;
		busAddr = a;
		busWdata = d;
	endtask
	// Released data shows the inverse so a stale byte cannot pass
	task automatic idle;
		put(1'b0, 1'b0, ~busAddr, ~busWdata);
	endtask
	// Callers send high then low on writes, low then high on reads
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		put(1'b1, 1'b0, a, d);
	endtask
endmodule

//--- tb/test_timer16_counter_core.sv
/* Self-checking bench for the timer core with a bus master model.
   Assumes the package, checker and model are compiled first. */
`timescale 1ns/100ps
module test_timer16_counter_core;
	logic clk = 1'b0;
	logic rst_n, busWrite, busRead, extPin, captureEvent, rdSeen;
	logic timerTick, atTop, atBottom, overflowFlag;
	logic [3:0] busAddr, waveformModeField;
	logic [7:0] busWdata, busRdata;
	logic [4:0] prescaleTap;
	logic [15:0] countValue, v;
	logic [7:0] expQ[$];
	int errCount, nTests;
	cpu_bus_model cpu (.clk(clk), .busAddr(busAddr), .busWrite(busWrite),
		.busRead(busRead), .busWdata(busWdata));
	timer16_counter_core dut (.clk(clk), .rst_n(rst_n), .busAddr(busAddr),
		.busWrite(busWrite), .busRead(busRead), .busWdata(busWdata),
		.busRdata(busRdata), .prescaleTap(prescaleTap), .extPin(extPin),
		.captureEvent(captureEvent), .timerTick(timerTick), .atTop(atTop),
		.atBottom(atBottom), .overflowFlag(overflowFlag),
		.waveformModeField(waveformModeField), .countValue(countValue));
	always #25 clk = ~clk;
	// ------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] e,
		input logic [15:0] s);
		nTests++;
		if (s !== e)
		begin
			errCount++;
			$display("FAIL %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic endOfTest;
		$display("checks %0d mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) rdSeen <= busRead && !busWrite;
	always @(negedge clk)
		if (rdSeen === 1'b1)
			check("busRdata", {8'h00, expQ.pop_front()}, {8'h00, busRdata});
	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		cpu.put(1'b0, 1'b1, a, 8'h00);
		expQ.push_back(e);
	endtask
	task automatic tap(input logic [4:0] t, input logic e);
		@(negedge clk) prescaleTap = t;
		#1 check("timerTick", {15'h0, e}, {15'h0, timerTick});
		@(negedge clk) prescaleTap = 5'h00;
	endtask
	task automatic load(input logic [15:0] d);
		cpu.wr(4'h5, d[15:8]);
		cpu.wr(4'h4, d[7:0]);
		cpu.idle();
	endtask
	initial
	begin
		#200000 errCount++;
		endOfTest();
	end
	initial
	begin
		rst_n = 1'b0;
		prescaleTap = 5'h00;
		extPin = 1'b1;
		captureEvent = 1'b0;
		v = 16'($urandom(81658));
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		check("countValue", 16'h0000, countValue);
		check("atBottom", 16'h0001, {15'h0, atBottom});
		// Back-to-back wide write then wide read, timer stopped
		v = 16'($urandom());
		cpu.wr(4'h5, v[15:8]);
		cpu.wr(4'h4, v[7:0]);
		rd(4'h4, v[7:0]);
		rd(4'h5, v[15:8]);
		cpu.idle();
		check("countValue", v, countValue);
		// One high byte shared by compare and counter writes
		cpu.wr(4'h5, v[15:8]);
		cpu.wr(4'h8, 8'h3C);
		cpu.wr(4'h4, 8'h5A);
		rd(4'h8, 8'h3C);
		cpu.wr(4'h5, ~v[15:8]);
		rd(4'h9, v[15:8]);
		cpu.idle();
		v[7:0] = 8'h5A;
		check("countValue", v, countValue);
		tap(5'h1F, 1'b0);
		check("countValue", v, countValue);
		for (int s = 1; s < 8; s++)
		begin
			cpu.wr(4'h1, 8'(s));
			cpu.idle();
			if (s < 6)
			begin
				tap(~(5'h01 << (s - 1)), 1'b0);
				tap(5'h01 << (s - 1), 1'b1);
			end
			else
			begin
				@(negedge clk) extPin = ~extPin;
				repeat (4) @(negedge clk);
			end
			v++;
			check("countValue", v, countValue);
		end
		cpu.wr(4'h1, 8'h01);
		load(16'hFFFF);
		check("atTop", 16'h0001, {15'h0, atTop});
		tap(5'h01, 1'b1);
		check("countValue", 16'h0000, countValue);
		check("overflowFlag", 16'h0001, {15'h0, overflowFlag});
		rd(4'hC, 8'h01);
		cpu.wr(4'hC, 8'h01);
		cpu.idle();
		check("overflowFlag", 16'h0000, {15'h0, overflowFlag});
		// Ticks in both write cycles; the low write must win
		cpu.wr(4'h5, 8'h12);
		prescaleTap = 5'h01;
		cpu.wr(4'h4, 8'h34);
		cpu.idle();
		prescaleTap = 5'h00;
		check("countValue", 16'h1234, countValue);
		@(negedge clk) captureEvent = 1'b1;
		@(negedge clk) captureEvent = 1'b0;
		cpu.wr(4'h5, 8'h00);
		rd(4'h6, 8'h34);
		rd(4'h7, 8'h12);
		for (int i = 0; i < 16; i++)
		begin
			cpu.wr(4'h0, {6'h00, 2'(i)});
			cpu.wr(4'h1, {3'h0, 2'(i >> 2), 3'h0});
			cpu.idle();
			check("waveformModeField", 16'(i), {12'h0, waveformModeField});
		end
		// Dual slope with top 00FF, then single slope clear at top
		cpu.wr(4'h0, 8'h01);
		cpu.wr(4'h1, 8'h01);
		load(16'h00FE);
		tap(5'h01, 1'b1);
		check("atTop", 16'h0001, {15'h0, atTop});
		tap(5'h01, 1'b1);
		check("countValue", 16'h00FE, countValue);
		// Still counting down: reach bottom, turn and raise the flag
		load(16'h0001);
		tap(5'h01, 1'b1);
		tap(5'h01, 1'b1);
		check("countValue", 16'h0001, countValue);
		check("overflowFlag", 16'h0001, {15'h0, overflowFlag});
		cpu.wr(4'h1, 8'h09);
		load(16'h00FF);
		tap(5'h01, 1'b1);
		check("countValue", 16'h0000, countValue);
		// Clear and a new overflow in one cycle: the set wins
		load(16'h00FF);
		cpu.wr(4'hC, 8'h01);
		prescaleTap = 5'h01;
		cpu.idle();
		prescaleTap = 5'h00;
		check("overflowFlag", 16'h0001, {15'h0, overflowFlag});
		// Clear at a compare top clears the count but sets no flag
		cpu.wr(4'hC, 8'h01);
		cpu.wr(4'h0, 8'h00);
		cpu.wr(4'h9, 8'h00);
		cpu.wr(4'h8, 8'h10);
		load(16'h0010);
		tap(5'h01, 1'b1);
		check("countValue", 16'h0000, countValue);
		check("overflowFlag", 16'h0000, {15'h0, overflowFlag});
		endOfTest();
	end
endmodule
